// ---- bench/periph_irq_enable_regs_tb.sv ----
// self-checking bench for the peripheral interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`include "irq_en_params.svh"
module periph_irq_enable_regs_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h00000000;
    logic [31:0] prd;
    logic [31:0] rd;
    logic [7:0]  fa = 8'h00;
    logic        prdy;
    logic        pirq;
    logic [7:0]  fb = 8'h00;
    logic        ce = 1'b1;
    logic        slv;
    logic        irq;
    logic        err;
    int          n_mismatch = 0;
    int          n_tests = 0;
    always #2.5 clk = ~clk;
    periph_irq_enable_regs uut (.CLK_IN(clk), .RESETN_IN(rstn), .CE_IN(ce), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd),
        .FLAG_SET_A_IN(fa), .FLAG_SET_B_IN(fb), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
        .PSLVERR_OUT(slv), .PERIPH_IRQ_OUT(pirq), .IRQ_OUT(irq));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // pready seen at a rising edge ends this wait; the watchdog only ends a wait that never sees it
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        err = slv;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic conclude;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_map;
        apb(1'b0, `OFS_EN_A, 0); chk("en_a reset", rd, 32'h00000000);
        apb(1'b0, `OFS_EN_B, 0); chk("en_b reset", rd, 32'h00000000);
        apb(1'b1, `OFS_EN_A, 32'hFFFFFFFF); apb(1'b0, `OFS_EN_A, 0);
        chk("en_a map", rd, 32'h000000FB);
        apb(1'b1, `OFS_EN_B, 32'hFFFFFFFF); apb(1'b0, `OFS_EN_B, 0);
        chk("en_b map", rd, 32'h000000EE);
        apb(1'b1, `OFS_EN_A, 0); apb(1'b1, `OFS_EN_B, 0);
        $display("test map done");
    endtask
    task automatic t_gate;
        fa <= 8'h01;
        @(posedge clk);
        fa <= 8'h00;
        apb(1'b0, `OFS_FLAG_A, 0); chk("flag without enable", rd[0], 1'b1);
        chk("irq disabled", pirq, 1'b0);
        apb(1'b1, `OFS_EN_A, 32'h00000001); apb(1'b1, `OFS_CTRL, 32'h00000001);
        repeat (3) @(posedge clk);
        chk("irq no group", pirq, 1'b0);
        apb(1'b1, `OFS_CTRL, 32'h00000003);
        repeat (3) @(posedge clk);
        chk("irq gated on", pirq, 1'b1);
        apb(1'b1, `OFS_EN_A, 0);
        repeat (3) @(posedge clk);
        chk("irq enable off", pirq, 1'b0);
        $display("test gate done");
    endtask
    task automatic t_clear;
        apb(1'b1, `OFS_FLAG_A, 32'h00000001); apb(1'b0, `OFS_FLAG_A, 0);
        chk("flag cleared first", rd, 32'h00000000);
        apb(1'b1, `OFS_EN_A, 32'h00000001);
        repeat (3) @(posedge clk);
        chk("no stale irq", pirq, 1'b0);
        apb(1'b1, `OFS_EN_B, 32'h00000004);
        fb <= 8'h15;
        @(posedge clk);
        fb <= 8'h00;
        repeat (3) @(posedge clk);
        chk("second bank irq", pirq, 1'b1);
        apb(1'b0, `OFS_FLAG_B, 0); chk("flag b absent bits", rd, 32'h00000004);
        $display("test clear done");
    endtask
    task automatic t_status;
        apb(1'b0, `OFS_STATUS, 0); chk("status event", rd, 32'h00000001);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, `OFS_MASK, 32'h00000001); chk("irq unmasked", irq, 1'b1);
        apb(1'b1, `OFS_STATUS, 32'h00000001); chk("irq after clear", irq, 1'b0);
        fb <= 8'h04;
        @(posedge clk);
        fb <= 8'h00;
        @(posedge clk);
        apb(1'b0, `OFS_STATUS, 0); chk("status lost", rd, 32'h00000002);
        chk("lost masked", irq, 1'b0);
        apb(1'b1, `OFS_MASK, 32'h00000003); chk("lost unmasked", irq, 1'b1);
        apb(1'b1, `OFS_STATUS, 32'h00000003); apb(1'b1, `OFS_MASK, 0);
        $display("test status done");
    endtask
    task automatic t_err;
        apb(1'b0, 12'h01C, 0); chk("unmapped error", err, 1'b1);
        chk("unmapped data", rd, 32'h00000000);
        apb(1'b0, `OFS_EN_B, 0); chk("mapped no error", err, 1'b0);
        chk("en_b held", rd, 32'h00000004);
        ce <= 1'b0;
        fa <= 8'h02;
        @(posedge clk);
        fa <= 8'h00;
        ce <= 1'b1;
        apb(1'b0, `OFS_FLAG_A, 0); chk("frozen flag", rd, 32'h00000000);
        $display("test error done");
    endtask
    task automatic t_reset;
        apb(1'b1, `OFS_EN_A, 32'h000000FF);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("irq after reset", pirq, 1'b0);
        apb(1'b0, `OFS_EN_A, 0); chk("en_a mid reset", rd, 32'h00000000);
        apb(1'b0, `OFS_EN_B, 0); chk("en_b mid reset", rd, 32'h00000000);
        $display("test reset done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_map();
        t_gate();
        t_clear();
        t_status();
        t_err();
        t_reset();
        conclude();
    end
    initial
    begin
        #20000;
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire

// ---- hw/apb_slave_port.sv ----
// apb slave handshake with one wait state
`timescale 1ns/1ps
`default_nettype none
module apb_slave_port
(
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  ce_in,
    input  wire irq_en_pkg::apb_req_t  req_in,
    input  wire logic [31:0]           rdata_in,
    input  wire logic                  hit_in,
    output logic                       wr_stb_out,
    output var irq_en_pkg::apb_rsp_t   rsp_out
);
    irq_en_pkg::apb_regs_t r_q;
    irq_en_pkg::apb_regs_t r_d;
    always_comb
    begin
        r_d = r_q;
        wr_stb_out = 1'b0;
        r_d.rsp.ready = 1'b0;
        case (r_q.st)
            irq_en_pkg::ST_IDLE:
            begin
                if (req_in.sel && req_in.en)
                begin
                    r_d.st = irq_en_pkg::ST_ACCESS;
                    r_d.rsp.ready = 1'b1;
                    r_d.rsp.rdata = req_in.wr ? 32'h0000_0000 : rdata_in;
                    r_d.rsp.slverr = !hit_in;
                end
            end
            irq_en_pkg::ST_ACCESS:
            begin
                wr_stb_out = req_in.wr && hit_in;
                r_d.st = irq_en_pkg::ST_IDLE;
            end
            default:
                r_d.st = irq_en_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            r_q <= '{st: irq_en_pkg::ST_IDLE, rsp: '0};
        else if (ce_in)
            r_q <= r_d;
    end
    assign rsp_out = r_q.rsp;
endmodule
`default_nettype wire

// ---- hw/irq_en_params.svh ----
// register map, field layout and reset values of the peripheral interrupt enable block
`ifndef IRQ_EN_PARAMS_SVH
`define IRQ_EN_PARAMS_SVH
`define OFS_EN_A        12'h000
`define OFS_EN_B        12'h004
`define OFS_FLAG_A      12'h008
`define OFS_FLAG_B      12'h00C
`define OFS_CTRL        12'h010
`define OFS_STATUS      12'h014
`define OFS_MASK        12'h018
`define MASK_EN_A       8'hFB
`define MASK_EN_B       8'hEE
`define RST_EN          8'h00
`define CTRL_GLOBAL_BIT 0
`define CTRL_GROUP_BIT  1
`define ST_IRQ_BIT      0
`define ST_LOST_BIT     1
`endif

// ---- hw/irq_en_pkg.sv ----
// types of the peripheral interrupt enable block
package irq_en_pkg;
    typedef struct packed {
        logic        sel;
        logic        en;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } apb_rsp_t;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } apb_state_t;
    typedef struct packed {
        apb_state_t  st;
        apb_rsp_t    rsp;
    } apb_regs_t;
    typedef struct packed {
        logic [7:0] flags;
    } flag_regs_t;
    typedef struct packed {
        logic [7:0] en_a;
        logic [7:0] en_b;
        logic [1:0] ctrl;
        logic [1:0] status;
        logic [1:0] mask;
        logic       irq;
        logic       pirq;
    } core_regs_t;
endpackage

// ---- hw/irq_flag_bank.sv ----
// one bank of sticky peripheral interrupt flags
`timescale 1ns/1ps
`default_nettype none
module irq_flag_bank
(
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    input  wire logic [7:0] impl_in,
    input  wire logic [7:0] set_in,
    input  wire logic [7:0] clr_in,
    output logic      [7:0] flags_out
);
    irq_en_pkg::flag_regs_t r_q;
    irq_en_pkg::flag_regs_t r_d;
    always_comb
    begin
        r_d = r_q;
        // set wins over a clear in the same cycle; enables play no part
        r_d.flags = ((r_q.flags & ~clr_in) | set_in) & impl_in;
    end
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            r_q <= '0;
        else if (ce_in)
            r_q <= r_d;
    end
    assign flags_out = r_q.flags;
    property p_set_sticky;
        @(posedge clk_in) disable iff (!resetn_in)
        ce_in && (set_in & impl_in) != 8'h00 |=>
            (flags_out & $past(set_in & impl_in)) == $past(set_in & impl_in);
    endproperty
    a_set_sticky: assert property (p_set_sticky)
        else $error("flag set was lost");
endmodule
`default_nettype wire

// ---- hw/periph_irq_enable_regs.sv ----
// peripheral interrupt enable registers with flags, group and global gating over apb
// Functional notes
// - flags set regardless of any enable
// - no interrupt without peripheral group enable, except IRQ_OUT from the lost-event status bit
// - enable bits writable, readable, reset zero
// - first register bit map, bit2 absent
// - second register bit map, bits 4,0 absent
`timescale 1ns/1ps
`default_nettype none
`include "irq_en_params.svh"
module periph_irq_enable_regs
(
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        CE_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic [7:0]  FLAG_SET_A_IN,
    input  wire logic [7:0]  FLAG_SET_B_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             PERIPH_IRQ_OUT,
    output logic             IRQ_OUT
);
    // bus carrier and the state of this module
    irq_en_pkg::apb_req_t   req;
    irq_en_pkg::apb_rsp_t   rsp;
    irq_en_pkg::core_regs_t r_q;
    irq_en_pkg::core_regs_t r_d;
    logic                   wr_stb;
    logic                   hit;
    logic [31:0]            rdata;
    logic [7:0]             wbyte;
    logic [7:0]             flags_a;
    logic [7:0]             flags_b;
    logic [7:0]             clr_a;
    logic [7:0]             clr_b;
    logic [1:0]             st_clr;
    logic                   lost;
    // one compare shared by the read decoder and every write target
    function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] ofs);
        addr_is = (addr == ofs);
    endfunction
    // ones written to a flag word select the bits to clear
    function automatic logic [7:0] clr_sel(input logic sel, input logic [7:0] data);
        clr_sel = sel ? data : 8'h00;
    endfunction
    // any flag that is pending and enabled in one bank
    function automatic logic pend_any(input logic [7:0] f, input logic [7:0] e);
        pend_any = |(f & e);
    endfunction
    // byte and two-bit registers read back zero extended
    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h00_0000, v};
    endfunction
    function automatic logic [31:0] zext2(input logic [1:0] v);
        zext2 = {30'h0000_0000, v};
    endfunction
    // the master's request travels as one carrier into the slave port
    assign req = '{sel:   PSEL_IN,
                   en:    PENABLE_IN,
                   wr:    PWRITE_IN,
                   addr:  PADDR_IN,
                   wdata: PWDATA_IN};
    assign wbyte = req.wdata[7:0];
    // one wait state: the answer is registered, so read data is taken from settled state
    apb_slave_port bus
    (
        .clk_in     (CLK_IN),
        .resetn_in  (RESETN_IN),
        .ce_in      (CE_IN),
        .req_in     (req),
        .rdata_in   (rdata),
        .hit_in     (hit),
        .wr_stb_out (wr_stb),
        .rsp_out    (rsp)
    );
    // read decoder
    always_comb
    begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        if (addr_is(req.addr, `OFS_EN_A))
        begin
            rdata = zext8(r_q.en_a);
        end
        else if (addr_is(req.addr, `OFS_EN_B))
        begin
            rdata = zext8(r_q.en_b);
        end
        else if (addr_is(req.addr, `OFS_FLAG_A))
        begin
            rdata = zext8(flags_a);
        end
        else if (addr_is(req.addr, `OFS_FLAG_B))
        begin
            rdata = zext8(flags_b);
        end
        else if (addr_is(req.addr, `OFS_CTRL))
        begin
            rdata = zext2(r_q.ctrl);
        end
        else if (addr_is(req.addr, `OFS_STATUS))
        begin
            rdata = zext2(r_q.status);
        end
        else if (addr_is(req.addr, `OFS_MASK))
        begin
            rdata = zext2(r_q.mask);
        end
        else
        begin
            // unmapped words read zero and answer with an error
            hit = 1'b0;
        end
    end
    // flags and status clear by writing ones; a coincident event still wins
    assign clr_a  = clr_sel(wr_stb && addr_is(req.addr, `OFS_FLAG_A), wbyte);
    assign clr_b  = clr_sel(wr_stb && addr_is(req.addr, `OFS_FLAG_B), wbyte);
    assign st_clr = (wr_stb && addr_is(req.addr, `OFS_STATUS)) ? wbyte[1:0] : 2'b00;
    // flags latch whatever the enables hold
    irq_flag_bank bank_a
    (
        .clk_in    (CLK_IN),
        .resetn_in (RESETN_IN),
        .ce_in     (CE_IN),
        .impl_in   (`MASK_EN_A),
        .set_in    (FLAG_SET_A_IN),
        .clr_in    (clr_a),
        .flags_out (flags_a)
    );
    irq_flag_bank bank_b
    (
        .clk_in    (CLK_IN),
        .resetn_in (RESETN_IN),
        .ce_in     (CE_IN),
        .impl_in   (`MASK_EN_B),
        .set_in    (FLAG_SET_B_IN),
        .clr_in    (clr_b),
        .flags_out (flags_b)
    );
    // a flag cannot count, so a second event on a pending flag is recorded here
    assign lost = |((FLAG_SET_A_IN & flags_a & ~clr_a) | (FLAG_SET_B_IN & flags_b & ~clr_b));
    // next state of enables, control, status and the two requests
    always_comb
    begin
        r_d = r_q;
        if (wr_stb)
        begin
            if (addr_is(req.addr, `OFS_EN_A))
            begin
                // absent positions are dropped on the way in
                r_d.en_a = wbyte & `MASK_EN_A;
            end
            else if (addr_is(req.addr, `OFS_EN_B))
            begin
                r_d.en_b = wbyte & `MASK_EN_B;
            end
            else if (addr_is(req.addr, `OFS_CTRL))
            begin
                r_d.ctrl = wbyte[1:0];
            end
            else if (addr_is(req.addr, `OFS_MASK))
            begin
                r_d.mask = wbyte[1:0];
            end
        end
        r_d.pirq = pend_any(flags_a, r_q.en_a) || pend_any(flags_b, r_q.en_b);
        if (!r_q.ctrl[`CTRL_GROUP_BIT] || !r_q.ctrl[`CTRL_GLOBAL_BIT])
        begin
            r_d.pirq = 1'b0;
        end
        r_d.status = r_q.status & ~st_clr;
        // events are applied after the clear so that a coincident event survives
        if (r_d.pirq && !r_q.pirq)
        begin
            r_d.status[`ST_IRQ_BIT] = 1'b1;
        end
        if (lost)
        begin
            r_d.status[`ST_LOST_BIT] = 1'b1;
        end
        // registered from next values so the level follows status and mask together
        r_d.irq = |(r_d.status & r_d.mask);
    end
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            r_q <= '{en_a:   `RST_EN,
                     en_b:   `RST_EN,
                     ctrl:   2'b00,
                     status: 2'b00,
                     mask:   2'b00,
                     irq:    1'b0,
                     pirq:   1'b0};
        else if (CE_IN)
            r_q <= r_d;
    end
    assign PRDATA_OUT     = rsp.rdata;
    assign PREADY_OUT     = rsp.ready;
    assign PSLVERR_OUT    = rsp.slverr;
    assign PERIPH_IRQ_OUT = r_q.pirq;
    assign IRQ_OUT        = r_q.irq;
    // checks on the gating and the register contents
    property p_group_gate;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        CE_IN && !r_q.ctrl[`CTRL_GROUP_BIT] |=> !PERIPH_IRQ_OUT;
    endproperty
    a_group_gate: assert property (p_group_gate)
        else $error("peripheral request without group enable");
    property p_pirq_def;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        CE_IN |=> PERIPH_IRQ_OUT == $past(|((flags_a & r_q.en_a) | (flags_b & r_q.en_b))
            && r_q.ctrl[`CTRL_GROUP_BIT] && r_q.ctrl[`CTRL_GLOBAL_BIT]);
    endproperty
    a_pirq_def: assert property (p_pirq_def)
        else $error("peripheral request differs from gated flags");
    property p_irq_level;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        IRQ_OUT == |(r_q.status & r_q.mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level differs from unmasked status");
    property p_absent_a;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r_q.en_a & ~`MASK_EN_A) == 8'h00;
    endproperty
    a_absent_a: assert property (p_absent_a)
        else $error("absent bit set in first enable register");
    property p_absent_b;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        (r_q.en_b & ~`MASK_EN_B) == 8'h00;
    endproperty
    a_absent_b: assert property (p_absent_b)
        else $error("absent bit set in second enable register");
    property p_status_set;
        @(posedge CLK_IN) disable iff (!RESETN_IN)
        CE_IN && r_d.pirq && !r_q.pirq |=> r_q.status[`ST_IRQ_BIT];
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("request rise not recorded in status");
    c_pirq_rise: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $rose(PERIPH_IRQ_OUT));
    c_irq_rise: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $rose(IRQ_OUT));
    c_lost: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        r_q.status[`ST_LOST_BIT]);
    c_bus_error: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        PREADY_OUT && PSLVERR_OUT);
endmodule
`default_nettype wire
